// file: pkg/loop_fault_pkg.sv
package loop_fault_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 25_000_000;
    localparam int RETRY_UNIT_MS   = 1;     // one step of the restore interval
    localparam int SILENCE_UNIT_MS = 50;    // one step of the link-silence limit
    localparam int PROBE_US        = 10;    // settle time of one restore attempt
    localparam int RETRY_UNIT_CYC  = (CLK_HZ / 1000) * RETRY_UNIT_MS;
    localparam int SILENCE_UNIT_CYC = (CLK_HZ / 1000) * SILENCE_UNIT_MS;
    localparam logic [23:0] PROBE_CYC = 24'((CLK_HZ / 1_000_000) * PROBE_US);

    // ------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------
    localparam logic [4:0] FRAME_LAST   = 5'h17;   // bit count 0..23, a frame is 24 bits
    localparam int         CMD_READ_BIT = 7;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_NONE         = 7'h00;
    localparam logic [6:0] ADDR_OUTPUT_CODE  = 7'h04;
    localparam logic [6:0] ADDR_STATUS       = 7'h05;
    localparam logic [6:0] ADDR_FAULT_CFG    = 7'h06;
    localparam logic [6:0] ADDR_ALARM_LOW    = 7'h07;
    localparam logic [6:0] ADDR_ALARM_HIGH   = 7'h08;
    localparam logic [6:0] ADDR_FAULT_STATUS = 7'h09;

    // ------------------------------------------------------------
    // fault configuration fields
    // ------------------------------------------------------------
    localparam int CFG_LOOP_ALARM_MASK = 0;
    localparam int CFG_LOOP_PIN_MASK   = 1;
    localparam int CFG_SILENCE_FAULT_MASK = 2;
    localparam int CFG_SILENCE_LOOP_MASK  = 3;
    localparam int CFG_NO_AUTO_RESTORE = 4;
    localparam int CFG_RETRY_LSB       = 5;   // 3 bits
    localparam int CFG_SILENCE_LSB     = 8;   // 3 bits

    // ------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------
    localparam int ST_FRAME      = 0;
    localparam int ST_LIVE_LOOP  = 1;
    localparam int ST_STICKY_LOOP = 2;
    localparam int ST_SILENCE    = 3;
    localparam int ST_BAND       = 4;
    localparam int ST_PIN        = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] OUTPUT_CODE_RESET = 16'h0000;
    localparam logic [15:0] FAULT_CFG_RESET   = 16'h0100;
    localparam logic [15:0] ALARM_LOW_RESET   = 16'h2400;
    localparam logic [15:0] ALARM_HIGH_RESET  = 16'hE800;

    typedef enum logic [1:0] {LOOP_OK, LOOP_ALARM, LOOP_PROBE} loop_state_t;

endpackage : loop_fault_pkg

// file: rtl/sync_bank.sv
`timescale 1ns/1ps
module sync_bank #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------
    // two-stage synchroniser per bit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_r;
            logic hold_r;
            // first stage is read only by the second
            always_ff @(posedge clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    meta_r <= 1'b0;
                    hold_r <= 1'b0;
                end
                else
                begin
                    meta_r <= async_in[i];
                    hold_r <= meta_r;
                end
            end
            assign sync_out[i] = hold_r;
        end
    endgenerate

endmodule : sync_bank

// file: rtl/loop_fault_alarm_logic.sv
`timescale 1ns/1ps
module loop_fault_alarm_logic
    import loop_fault_pkg::*;
#(
    parameter int RETRY_STEP_CYC   = RETRY_UNIT_CYC,
    parameter int SILENCE_STEP_CYC = SILENCE_UNIT_CYC
) (
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic        sclk_in,
    input  wire logic        chip_select_n_in,
    input  wire logic        sdi_in,
    output logic             sdo_out,
    output logic             sdo_oe_out,
    input  wire logic        loop_drive_fail_in,
    input  wire logic        alarm_band_select_in,
    input  wire logic        fault_n_pin_in,
    output logic             fault_n_pin_out,
    output logic             fault_n_pin_oe_out,
    output logic [15:0]      loop_current_code_out
);

    // ------------------------------------------------------------
    // reset release and input synchronisation
    // ------------------------------------------------------------
    logic        rst_meta_r;
    logic        rst_n;
    logic [5:0]  pins_s;
    logic        sclk_s, cs_on_s, sdi_s, fail_s, band_s, pin_low_s;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    sync_bank #(.WIDTH(6)) u_sync (
        .clk_in   (clk_sys_in),
        .rst_n_in (rst_n),
        .async_in ({~fault_n_pin_in, alarm_band_select_in, loop_drive_fail_in,
                    sdi_in, ~chip_select_n_in, sclk_in}),
        .sync_out (pins_s)
    );
    assign {pin_low_s, band_s, fail_s, sdi_s, cs_on_s, sclk_s} = pins_s;
    // idle-high pins pass inverted: the stages reset to 0, so no false
    // chip select edge follows reset
    wire cs_s  = ~cs_on_s;
    wire pin_s = ~pin_low_s;

    // ------------------------------------------------------------
    // serial shifter
    // ------------------------------------------------------------
    logic        sclk_d_r, cs_d_r, done_r, got_clk_r, sdo_r;
    logic [4:0]  bit_cnt_r;
    logic [23:0] shift_r;
    logic [15:0] rd_data;

    // edges seen on the synchronised copies only
    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire sclk_fall = ~sclk_s & sclk_d_r;
    wire cs_fall   = ~cs_s & cs_d_r;
    wire cs_rise   = cs_s & ~cs_d_r;
    wire [7:0] cmd  = shift_r[23:16];
    wire [6:0] addr = cmd[6:0];
    wire [4:0] bit_cnt_nxt = (bit_cnt_r == FRAME_LAST) ? 5'h00 : bit_cnt_r + 5'h01;
    // decode one cycle after chip select rises; a last clock edge
    // that lands in the same sample as the rise is not shifted in
    // count framing check
    wire frame_bad = done_r & got_clk_r & (bit_cnt_r != 5'h00);
    wire frame_ok  = done_r & got_clk_r & (bit_cnt_r == 5'h00);
    wire load_rd   = frame_ok & cmd[CMD_READ_BIT];
    // address zero never counts as a write
    wire wr_valid  = frame_ok & ~cmd[CMD_READ_BIT] & (addr != ADDR_NONE);

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_d_r  <= 1'b0;
            cs_d_r    <= 1'b1;
            done_r    <= 1'b0;
            got_clk_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            shift_r   <= 24'h000000;
            sdo_r     <= 1'b0;
        end
        else
        begin
            sclk_d_r <= sclk_s;
            cs_d_r   <= cs_s;
            done_r   <= cs_rise;
            if (cs_fall)
            begin
                bit_cnt_r <= 5'h00;
                got_clk_r <= 1'b0;
                sdo_r     <= shift_r[23];
            end
            else if (sclk_rise && !cs_s)
            begin
                shift_r   <= {shift_r[22:0], sdi_s};
                bit_cnt_r <= bit_cnt_nxt;
                got_clk_r <= 1'b1;
            end
            else if (sclk_fall && !cs_s)
                sdo_r <= shift_r[23];
            else if (load_rd)
                shift_r <= {cmd, rd_data};
        end
    end

    assign sdo_out    = sdo_r;
    assign sdo_oe_out = ~cs_s;

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    logic [15:0] output_code_r, cfg_r, alarm_low_r, alarm_high_r;
    wire code_wr = wr_valid & (addr == ADDR_OUTPUT_CODE);

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            output_code_r <= OUTPUT_CODE_RESET;
            cfg_r         <= FAULT_CFG_RESET;
            alarm_low_r   <= ALARM_LOW_RESET;
            alarm_high_r  <= ALARM_HIGH_RESET;
        end
        else if (wr_valid)
        begin
            if (addr == ADDR_OUTPUT_CODE)
                output_code_r <= shift_r[15:0];
            if (addr == ADDR_FAULT_CFG)
                cfg_r <= shift_r[15:0];
            if (addr == ADDR_ALARM_LOW)
                alarm_low_r <= shift_r[15:0];
            if (addr == ADDR_ALARM_HIGH)
                alarm_high_r <= shift_r[15:0];
        end
    end

    wire       loop_alarm_mask = cfg_r[CFG_LOOP_ALARM_MASK];
    wire       loop_pin_mask   = cfg_r[CFG_LOOP_PIN_MASK];
    wire       silence_fault_mask = cfg_r[CFG_SILENCE_FAULT_MASK];
    wire       silence_loop_mask  = cfg_r[CFG_SILENCE_LOOP_MASK];
    wire       no_auto_restore = cfg_r[CFG_NO_AUTO_RESTORE];
    wire [2:0] retry_field     = cfg_r[CFG_RETRY_LSB +: 3];
    wire [2:0] silence_field   = cfg_r[CFG_SILENCE_LSB +: 3];

    // ------------------------------------------------------------
    // loop fault state machine
    // ------------------------------------------------------------
    loop_state_t loop_state_r, loop_state_nxt;
    logic        live_r, live_nxt, sticky_loop_r, cnt_clr;
    logic [23:0] loop_cnt_r;
    wire  [23:0] retry_limit = 24'(({21'h0, retry_field} + 24'h1) * 24'(RETRY_STEP_CYC));
    wire         status_clr  = load_rd & (addr == ADDR_STATUS);
    wire         recheck_req = load_rd & (addr == ADDR_FAULT_STATUS);
    // manual mode waits for fault status read or a code write
    wire retry_go = code_wr | (no_auto_restore ? recheck_req
                                               : (loop_cnt_r >= retry_limit - 24'h1));
    wire probe_end = (loop_cnt_r >= PROBE_CYC - 24'h1);

    always_comb
    begin
        loop_state_nxt = loop_state_r;
        live_nxt       = live_r;
        cnt_clr        = 1'b0;
        case (loop_state_r)
            LOOP_OK:
            begin
                cnt_clr  = 1'b1;
                // masked faults are still reported live
                live_nxt = loop_alarm_mask & fail_s;
                if (fail_s && !loop_alarm_mask)
                begin
                    loop_state_nxt = LOOP_ALARM;
                    live_nxt       = 1'b1;
                end
            end
            LOOP_ALARM:
            begin
                if (loop_alarm_mask)
                begin
                    loop_state_nxt = LOOP_OK;
                    live_nxt       = fail_s;
                end
                else if (retry_go)
                begin
                    loop_state_nxt = LOOP_PROBE;
                    cnt_clr        = 1'b1;
                end
            end
            LOOP_PROBE:
            begin
                if (loop_alarm_mask)
                    loop_state_nxt = LOOP_OK;
                else if (probe_end && fail_s)
                begin
                    loop_state_nxt = LOOP_ALARM;
                    cnt_clr        = 1'b1;
                end
                else if (probe_end)
                begin
                    loop_state_nxt = LOOP_OK;
                    live_nxt       = 1'b0;
                end
            end
            default:
            begin
                loop_state_nxt = LOOP_OK;
                live_nxt       = 1'b0;
            end
        endcase
    end

    // a fault that was live while masked still marks sticky on alarm entry
    wire alarm_entry = (loop_state_r == LOOP_OK) & (loop_state_nxt == LOOP_ALARM);
    // sticky clears only on status read, a new fault wins
    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loop_state_r  <= LOOP_OK;
            live_r        <= 1'b0;
            sticky_loop_r <= 1'b0;
            loop_cnt_r    <= 24'h000000;
        end
        else
        begin
            loop_state_r  <= loop_state_nxt;
            live_r        <= live_nxt;
            sticky_loop_r <= (live_nxt & ~live_r) | alarm_entry | (sticky_loop_r & ~status_clr);
            loop_cnt_r    <= cnt_clr ? 24'h000000 : loop_cnt_r + 24'h000001;
        end
    end

    // ------------------------------------------------------------
    // link silence and frame fault
    // ------------------------------------------------------------
    logic        sil_to_r, frame_sticky_r, init_r;
    logic [23:0] sil_cnt_r;
    wire  [23:0] sil_limit = 24'(({21'h0, silence_field} + 24'h1) * 24'(SILENCE_STEP_CYC));

    // silence counter flags timeout at limit
    // restart at end of valid write frame to a nonzero address
    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sil_cnt_r <= 24'h000000;
            sil_to_r  <= 1'b0;
        end
        else if (wr_valid)
        begin
            sil_cnt_r <= 24'h000000;
            sil_to_r  <= 1'b0;
        end
        else if (!sil_to_r)
        begin
            sil_cnt_r <= sil_cnt_r + 24'h000001;
            sil_to_r  <= (sil_cnt_r >= sil_limit - 24'h1);
        end
    end

    // frame flag: set wins over the status-read clear
    // alarm band held from power-up until first code
    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frame_sticky_r <= 1'b0;
            init_r         <= 1'b1;
        end
        else
        begin
            frame_sticky_r <= frame_bad | (frame_sticky_r & ~status_clr);
            if (code_wr)
                init_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status view and output selection
    // ------------------------------------------------------------
    // one status word for both read addresses
    wire [15:0] status_word = {10'h000, pin_s, band_s, sil_to_r, sticky_loop_r,
                               live_r, frame_sticky_r};
    assign rd_data = (addr == ADDR_STATUS || addr == ADDR_FAULT_STATUS) ? status_word :
                     (addr == ADDR_OUTPUT_CODE) ? output_code_r :
                     (addr == ADDR_FAULT_CFG)   ? cfg_r :
                     (addr == ADDR_ALARM_LOW)   ? alarm_low_r :
                     (addr == ADDR_ALARM_HIGH)  ? alarm_high_r : 16'h0000;

    wire sil_report  = sil_to_r & ~silence_fault_mask;
    wire sil_on_loop = sil_report & ~silence_loop_mask;
    wire loop_alarm  = (loop_state_r == LOOP_ALARM);
    wire probing     = (loop_state_r == LOOP_PROBE);
    wire band_alarm  = (sil_on_loop | init_r) & ~probing;
    // band codes kept in alarm registers
    // band pin picks silence alarm level
    wire [15:0] band_code = band_s ? alarm_high_r : alarm_low_r;
    wire [15:0] code_nxt = loop_alarm ? alarm_low_r :
                           band_alarm ? band_code : output_code_r;
    // pin pulled while any unmasked fault stands
    wire fault_act = (live_r & ~loop_pin_mask) | sil_report | frame_sticky_r;
    logic [15:0] code_r;
    logic        fault_oe_r;

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_r     <= ALARM_LOW_RESET;
            fault_oe_r <= 1'b0;
        end
        else
        begin
            code_r     <= code_nxt;
            fault_oe_r <= fault_act;
        end
    end

    assign loop_current_code_out = code_r;
    assign fault_n_pin_out       = 1'b0;        // open drain: only ever pulls low
    assign fault_n_pin_oe_out    = fault_oe_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_loop_alarm_low: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        loop_alarm |=> (code_r == $past(alarm_low_r)))
        else $error("loop alarm not at low level");

    a_band_high_sel: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (sil_on_loop && band_s && loop_state_r == LOOP_OK) |=> (code_r == $past(alarm_high_r)))
        else $error("silence alarm not at high level");

    a_sticky_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (sticky_loop_r && !status_clr) |=> sticky_loop_r)
        else $error("sticky loop bit dropped without read");

    a_fault_sets_bits: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (loop_state_r == LOOP_OK && fail_s && !loop_alarm_mask) |=> (live_r && sticky_loop_r))
        else $error("loop fault did not set status bits");

    a_manual_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (loop_alarm && no_auto_restore && !loop_alarm_mask && !recheck_req && !code_wr)
        |=> (loop_state_r == LOOP_ALARM))
        else $error("restore attempted without status read");

    a_frame_pin_low: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        frame_bad |=> ##1 fault_n_pin_oe_out)
        else $error("frame fault did not pull pin");

    a_frame_no_restart: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (frame_bad && !sil_to_r) |=> (sil_cnt_r == $past(sil_cnt_r) + 24'h1))
        else $error("bad frame restarted silence timer");

    a_addr0_no_restart: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (frame_ok && cmd == 8'h00 && !sil_to_r) |=> (sil_cnt_r == $past(sil_cnt_r) + 24'h1))
        else $error("address zero write restarted silence timer");

    a_silence_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (!sil_to_r && !wr_valid && sil_cnt_r == sil_limit - 24'h1) |=> sil_to_r)
        else $error("silence limit reached without timeout");

    a_probe_bound: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (probing && probe_end && !fail_s && !loop_alarm_mask) |=> (!live_r && !loop_alarm))
        else $error("successful restore left fault live");

endmodule : loop_fault_alarm_logic

// file: verif/serial_master.sv
`timescale 1ns/1ps
// host-side serial master, idles with sclk low
module serial_master
(
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      sdi_out,
    input  wire logic sdo_in
);
    localparam time HALF = 160ns;

    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out  = 1'b0;
    end

    // one frame, msb first; rx keeps the last 24 bits seen on sdo
    // read command built with bit 7 set
    task automatic xfer(input int nbits, input logic [23:0] word,
                        output logic [23:0] rx);
        rx = 24'h000000;
        cs_n_out = 1'b0;
        #(HALF);
        for (int i = nbits - 1; i >= 0; i--)
        begin
            sdi_out = word[i];
            #(HALF);
            sclk_out = 1'b1;
            rx = {rx[22:0], sdo_in};
            #(HALF);
            sclk_out = 1'b0;
        end
        #(HALF);
        cs_n_out = 1'b1;
        // released data line must not look like a held bit
        sdi_out = ~sdi_out;
        #(HALF * 4);
    endtask : xfer
endmodule : serial_master

// file: verif/loop_fault_alarm_logic_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %0t: got %h want %h", $time, a, e); end end
module loop_fault_alarm_logic_tb;
    import loop_fault_pkg::*;
    logic        clk_sys, resetn, sclk, cs_n, sdi, sdo, sdo_oe;
    logic        fail, band, pin_oe, pin_drv, pin_lvl, sdo_line;
    logic [15:0] code, st;
    logic [23:0] rx;
    int          err_total  = 0;
    int          num_checks = 0;
    int          cycles     = 0;

    // fault pin has a pull-up outside the device
    assign pin_lvl = pin_oe ? pin_drv : 1'b1;
    // released data line shows the inverse, so a late enable is caught
    assign sdo_line = sdo_oe ? sdo : ~sdo;

    loop_fault_alarm_logic #(.RETRY_STEP_CYC(40), .SILENCE_STEP_CYC(400)) i_dut (
        .clk_sys_in(clk_sys), .resetn_in(resetn), .sclk_in(sclk),
        .chip_select_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
        .loop_drive_fail_in(fail), .alarm_band_select_in(band),
        .fault_n_pin_in(pin_lvl), .fault_n_pin_out(pin_drv),
        .fault_n_pin_oe_out(pin_oe), .loop_current_code_out(code));

    serial_master i_master (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo_line));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // watchdog sized well above the whole sequence
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            $display("ERROR %0t: run hung", $time);
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : step

    task automatic wr(input logic [6:0] addr, input logic [15:0] data);
        i_master.xfer(24, {1'b0, addr, data}, rx);
    endtask : wr

    // two frames: command, then shift the answer out
    task automatic rd(input logic [6:0] addr, output logic [15:0] data);
        i_master.xfer(24, {1'b1, addr, 16'h0000}, rx);
        i_master.xfer(24, 24'h000000, rx);
        `CHK(rx[23:16], {1'b1, addr})
        data = rx[15:0];
    endtask : rd

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial
    begin
        resetn = 1'b0;
        fail   = 1'b0;
        band   = 1'b1;
        step(6);
        resetn = 1'b1;
        step(8);
        `CHK(code, ALARM_HIGH_RESET)
        `CHK(sdo_oe, 1'b0)
        wr(ADDR_FAULT_CFG, 16'h0700);
        wr(ADDR_OUTPUT_CODE, 16'h1234);
        step(2);
        `CHK(code, 16'h1234)
        fail = 1'b1;
        step(8);
        `CHK(code, ALARM_LOW_RESET)
        `CHK(pin_oe, 1'b1)
        rd(ADDR_FAULT_STATUS, st);
        `CHK(st, 16'h0016)
        fail = 1'b0;
        // retry step plus probe time bound the recovery
        step(700);
        `CHK(code, 16'h1234)
        `CHK(pin_oe, 1'b0)
        rd(ADDR_FAULT_STATUS, st);
        `CHK(st, 16'h0034)
        rd(ADDR_STATUS, st);
        `CHK(st, 16'h0034)
        rd(ADDR_STATUS, st);
        `CHK(st, 16'h0030)
        // short frame must not touch the output
        wr(ADDR_FAULT_CFG, 16'h0700);
        i_master.xfer(23, {1'b0, ADDR_OUTPUT_CODE, 16'h5555}, rx);
        step(2);
        `CHK(pin_oe, 1'b1)
        `CHK(code, 16'h1234)
        rd(ADDR_STATUS, st);
        `CHK(st, 16'h0011)
        step(2);
        `CHK(pin_oe, 1'b0)
        // shortest silence limit; neither later write restarts it
        wr(ADDR_FAULT_CFG, 16'h0000);
        step(100);
        wr(ADDR_NONE, 16'h1111);
        i_master.xfer(23, {1'b0, ADDR_OUTPUT_CODE, 16'h1234}, rx);
        step(20);
        `CHK(code, ALARM_HIGH_RESET)
        `CHK(pin_oe, 1'b1)
        band = 1'b0;
        step(4);
        `CHK(code, ALARM_LOW_RESET)
        band = 1'b1;
        fail = 1'b1;
        step(8);
        `CHK(code, ALARM_LOW_RESET)
        fail = 1'b0;
        // loop mask only: timeout still pulls the pin, current kept
        wr(ADDR_FAULT_CFG, 16'h0008);
        rd(ADDR_STATUS, st);
        step(600);
        `CHK(code, 16'h1234)
        `CHK(pin_oe, 1'b1)
        wr(ADDR_FAULT_CFG, 16'h0004);
        step(500);
        `CHK(code, 16'h1234)
        `CHK(pin_oe, 1'b0)
        rd(ADDR_FAULT_STATUS, st);
        `CHK(st[3], 1'b1)
        // masked loop fault: live and sticky only, no alarm current, no pin
        wr(ADDR_ALARM_LOW, 16'h1800);
        wr(ADDR_FAULT_CFG, 16'h000F);
        fail = 1'b1;
        step(8);
        `CHK(code, 16'h1234)
        `CHK(pin_oe, 1'b0)
        // manual restore: alarm holds until the fault status read
        wr(ADDR_FAULT_CFG, 16'h001C);
        step(8);
        `CHK(code, 16'h1800)
        fail = 1'b0;
        step(400);
        `CHK(code, 16'h1800)
        rd(ADDR_FAULT_STATUS, st);
        `CHK(st[ST_LIVE_LOOP], 1'b1)
        step(60);
        `CHK(code, 16'h1234)
        stop_test();
    end
endmodule : loop_fault_alarm_logic_tb
